// ---- design/mfc_pkg.sv ----
// shared constants for the modulation and frequency configuration bank
package mfc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_MOD_CTRL = 8'h71;
  localparam logic [7:0] ADDR_DEV = 8'h72;
  localparam logic [7:0] ADDR_OFS_LO = 8'h73;
  localparam logic [7:0] ADDR_OFS_HI = 8'h74;
  localparam logic [7:0] ADDR_BAND = 8'h75;
  localparam logic [7:0] ADDR_FRAC_HI = 8'h76;
  localparam logic [7:0] ADDR_FRAC_LO = 8'h77;
  localparam logic [7:0] ADDR_HOP_CH = 8'h79;
  localparam logic [7:0] ADDR_HOP_STEP = 8'h7A;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_MOD_CTRL = 8'h00;
  localparam logic [7:0] RST_DEV = 8'h20;
  localparam logic [7:0] RST_OFS = 8'h00;
  localparam logic [6:0] RST_BAND = 7'h75;
  localparam logic [7:0] RST_FRAC_HI = 8'hBB;
  localparam logic [7:0] RST_FRAC_LO = 8'h80;
  localparam logic [7:0] RST_HOP = 8'h00;
  localparam logic [8:0] PN_SEED = 9'h1FF;
  // ==========================================================
  // field positions
  localparam int ROUTE_HI = 7;
  localparam int ROUTE_LO = 6;
  localparam int SRC_HI = 5;
  localparam int SRC_LO = 4;
  localparam int INV_BIT = 3;
  localparam int DEV_MSB_BIT = 2;
  localparam int KIND_HI = 1;
  localparam int KIND_LO = 0;
  localparam int SIDE_BIT = 6;
  localparam int HBAND_BIT = 5;
  localparam int FB_HI = 4;
  localparam int PN_TAP = 5;
  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    ROUTE_NONE = 2'b00,
    ROUTE_GPIO = 2'b01,
    ROUTE_SDO = 2'b10,
    ROUTE_IRQ = 2'b11
  } mfc_route_e;
  typedef enum logic [1:0] {
    SRC_GPIO = 2'b00,
    SRC_SDI = 2'b01,
    SRC_FIFO = 2'b10,
    SRC_PN9 = 2'b11
  } mfc_src_e;
  typedef enum logic [1:0] {
    KIND_CW = 2'b00,
    KIND_OOK = 2'b01,
    KIND_FSK = 2'b10,
    KIND_GFSK = 2'b11
  } mfc_kind_e;
  // ==========================================================
  // frequency arithmetic
  localparam int DEV_STEP_HZ = 625;
  localparam int BAND_BASE_IDX = 24;
  localparam int BAND_STEP_MHZ = 10;
  localparam int LOW_BASE_MHZ = 240;
  localparam int CAR_SCALE_KHZ = 10000;
  localparam int CAR_FRAC_DEN = 64000;
  localparam int HOP_UNIT_KHZ = 10;
endpackage : mfc_pkg

// ---- design/mfc_link_if.sv ----
// register port and direct data pins between controller and radio
`timescale 1ns/1ps
`default_nettype none
interface mfc_link_if;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic [7:0] regRdata;
  logic selPin;
  logic sdiData;
  modport dev (
    input regAddr,
    input regWdata,
    input regWr,
    input regRd,
    output regRdata,
    input selPin,
    input sdiData
  );
  modport host (
    output regAddr,
    output regWdata,
    output regWr,
    output regRd,
    input regRdata,
    output selPin,
    output sdiData
  );
endinterface : mfc_link_if
`default_nettype wire

// ---- design/mfc_device.sv ----
// radio end: modulation and frequency configuration register bank
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mfc_device (
  input wire logic clk,
  input wire logic rstn,
  mfc_link_if.dev link,
  input wire logic bitTick,
  input wire logic gpioDataIn,
  input wire logic fifoDataIn,
  input wire logic rxDataRaw,
  input wire logic afcValid,
  input wire logic [9:0] afcResult,
  output logic txData,
  output logic rxData,
  output logic dataClkGpio,
  output logic dataClkSdo,
  output logic dataClkIrq,
  output logic [1:0] modulationKind,
  output logic [1:0] dataSource,
  output logic highBand,
  output logic sideBand,
  output logic [18:0] deviationHz,
  output logic signed [10:0] offsetUnits,
  output logic [10:0] bandStartMhz,
  output logic [21:0] carrierKhz
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] modCtrl;
    logic [7:0] devLow;
    logic [7:0] ofsLow;
    logic [1:0] ofsHigh;
    logic [6:0] band;
    logic [7:0] fracHigh;
    logic [7:0] fracLow;
    logic [7:0] hopCh;
    logic [7:0] hopStep;
    logic [9:0] afc;
    logic [7:0] rdata;
    logic [8:0] pn;
    logic clkTgl;
    logic txData;
    logic rxData;
    logic clkGpio;
    logic clkSdo;
    logic clkIrq;
    logic [18:0] devHz;
    logic signed [10:0] ofsUnits;
    logic [10:0] bandMhz;
    logic [21:0] carKhz;
  } mfc_dev_s;

  mfc_dev_s q_ff;
  mfc_dev_s nxt_q;

  // ==========================================================
  // helpers
  // nominal carrier in kHz, truncated toward zero on the fraction
  function automatic logic [21:0] carrier_khz(input logic [4:0] fb, input logic hb,
      input logic [15:0] fc, input logic [9:0] fo, input logic [7:0] ch, input logic [7:0] st);
    int frac;
    int base;
    int total;
    frac = ((int'(fc) + int'($signed(fo))) * mfc_pkg::CAR_SCALE_KHZ) / mfc_pkg::CAR_FRAC_DEN;
    base = (int'(fb) + mfc_pkg::BAND_BASE_IDX) * mfc_pkg::CAR_SCALE_KHZ + frac;
    total = base * (int'(hb) + 1) + int'(ch) * int'(st) * mfc_pkg::HOP_UNIT_KHZ;
    return total[21:0];
  endfunction : carrier_khz

  wire logic [1:0] route = q_ff.modCtrl[mfc_pkg::ROUTE_HI:mfc_pkg::ROUTE_LO];
  wire logic [1:0] source = q_ff.modCtrl[mfc_pkg::SRC_HI:mfc_pkg::SRC_LO];
  wire logic invert = q_ff.modCtrl[mfc_pkg::INV_BIT];
  wire logic hb = q_ff.band[mfc_pkg::HBAND_BIT];
  wire logic [4:0] fb = q_ff.band[mfc_pkg::FB_HI:0];
  wire logic [9:0] foWritten = {q_ff.ofsHigh, q_ff.ofsLow};

  // ==========================================================
  // next state
  always_comb begin
    logic srcBit;
    srcBit = 1'b0;
    nxt_q = q_ff;
    // register writes; reserved bits are dropped so they read as zero
    if (link.regWr) begin
      unique case (link.regAddr)
        mfc_pkg::ADDR_MOD_CTRL: nxt_q.modCtrl = link.regWdata;
        mfc_pkg::ADDR_DEV: nxt_q.devLow = link.regWdata;
        mfc_pkg::ADDR_OFS_LO: nxt_q.ofsLow = link.regWdata;
        mfc_pkg::ADDR_OFS_HI: nxt_q.ofsHigh = link.regWdata[1:0];
        mfc_pkg::ADDR_BAND: nxt_q.band = link.regWdata[6:0];
        mfc_pkg::ADDR_FRAC_HI: nxt_q.fracHigh = link.regWdata;
        mfc_pkg::ADDR_FRAC_LO: nxt_q.fracLow = link.regWdata;
        mfc_pkg::ADDR_HOP_CH: nxt_q.hopCh = link.regWdata;
        mfc_pkg::ADDR_HOP_STEP: nxt_q.hopStep = link.regWdata;
        default: nxt_q.hopCh = q_ff.hopCh; // unmapped writes are ignored
      endcase
    end
    // correction result from the demodulator
    if (afcValid) begin
      nxt_q.afc = afcResult;
    end
    // read data valid in the cycle after the strobe, zero elsewhere
    nxt_q.rdata = 8'h00;
    if (link.regRd) begin
      unique case (link.regAddr)
        mfc_pkg::ADDR_MOD_CTRL: nxt_q.rdata = q_ff.modCtrl;
        mfc_pkg::ADDR_DEV: nxt_q.rdata = q_ff.devLow;
        mfc_pkg::ADDR_OFS_LO: nxt_q.rdata = q_ff.afc[7:0];
        mfc_pkg::ADDR_OFS_HI: nxt_q.rdata = {6'h00, q_ff.afc[9:8]};
        mfc_pkg::ADDR_BAND: nxt_q.rdata = {1'b0, q_ff.band};
        mfc_pkg::ADDR_FRAC_HI: nxt_q.rdata = q_ff.fracHigh;
        mfc_pkg::ADDR_FRAC_LO: nxt_q.rdata = q_ff.fracLow;
        mfc_pkg::ADDR_HOP_CH: nxt_q.rdata = q_ff.hopCh;
        mfc_pkg::ADDR_HOP_STEP: nxt_q.rdata = q_ff.hopStep;
        default: nxt_q.rdata = 8'h00;
      endcase
    end
    // data clock: one toggle per bit, routed to a single pin
    if (bitTick) begin
      nxt_q.clkTgl = ~q_ff.clkTgl;
    end
    nxt_q.clkGpio = (route == mfc_pkg::ROUTE_GPIO) && q_ff.clkTgl;
    nxt_q.clkSdo = (route == mfc_pkg::ROUTE_SDO) && q_ff.clkTgl;
    nxt_q.clkIrq = (route == mfc_pkg::ROUTE_IRQ) && q_ff.clkTgl;
    // pseudo-random sequence advances only while selected
    if (bitTick && source == mfc_pkg::SRC_PN9) begin
      nxt_q.pn = {q_ff.pn[0] ^ q_ff.pn[mfc_pkg::PN_TAP], q_ff.pn[8:1]};
    end
    // source select; SDI holds the last bit while the select pin is low
    unique case (source)
      mfc_pkg::SRC_GPIO: srcBit = gpioDataIn;
      mfc_pkg::SRC_SDI: srcBit = link.selPin ? link.sdiData : (q_ff.txData ^ invert);
      mfc_pkg::SRC_FIFO: srcBit = fifoDataIn;
      mfc_pkg::SRC_PN9: srcBit = q_ff.pn[0];
    endcase
    nxt_q.txData = srcBit ^ invert;
    nxt_q.rxData = rxDataRaw ^ invert;
    // derived frequency figures, all registered
    nxt_q.devHz = 19'(int'({q_ff.modCtrl[mfc_pkg::DEV_MSB_BIT], q_ff.devLow})
      * mfc_pkg::DEV_STEP_HZ);
    nxt_q.ofsUnits = hb ? {$signed(foWritten), 1'b0} : 11'($signed(foWritten));
    nxt_q.bandMhz = 11'((mfc_pkg::LOW_BASE_MHZ + int'(fb) * mfc_pkg::BAND_STEP_MHZ)
      * (int'(hb) + 1));
    nxt_q.carKhz = carrier_khz(fb, hb, {q_ff.fracHigh, q_ff.fracLow}, foWritten,
      q_ff.hopCh, q_ff.hopStep);
  end

  // ==========================================================
  // registers with printed reset values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
      q_ff.modCtrl <= mfc_pkg::RST_MOD_CTRL;
      q_ff.devLow <= mfc_pkg::RST_DEV;
      q_ff.ofsLow <= mfc_pkg::RST_OFS;
      q_ff.band <= mfc_pkg::RST_BAND;
      q_ff.fracHigh <= mfc_pkg::RST_FRAC_HI;
      q_ff.fracLow <= mfc_pkg::RST_FRAC_LO;
      q_ff.hopCh <= mfc_pkg::RST_HOP;
      q_ff.hopStep <= mfc_pkg::RST_HOP;
      q_ff.pn <= mfc_pkg::PN_SEED;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================
  // outputs
  assign link.regRdata = q_ff.rdata;
  assign txData = q_ff.txData;
  assign rxData = q_ff.rxData;
  assign dataClkGpio = q_ff.clkGpio;
  assign dataClkSdo = q_ff.clkSdo;
  assign dataClkIrq = q_ff.clkIrq;
  assign modulationKind = q_ff.modCtrl[mfc_pkg::KIND_HI:mfc_pkg::KIND_LO];
  assign dataSource = q_ff.modCtrl[mfc_pkg::SRC_HI:mfc_pkg::SRC_LO];
  assign highBand = q_ff.band[mfc_pkg::HBAND_BIT];
  assign sideBand = q_ff.band[mfc_pkg::SIDE_BIT];
  assign deviationHz = q_ff.devHz;
  assign offsetUnits = q_ff.ofsUnits;
  assign bandStartMhz = q_ff.bandMhz;
  assign carrierKhz = q_ff.carKhz;
endmodule : mfc_device
`default_nettype wire

// ---- design/mfc_host.sv ----
// controller end: issues register accesses and drives direct data
`timescale 1ns/1ps
`default_nettype none
module mfc_host (
  input wire logic clk,
  input wire logic rstn,
  mfc_link_if.host link,
  input wire logic cmdWr,
  input wire logic cmdRd,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic directEn,
  input wire logic directBit,
  output logic [7:0] rspData,
  output logic rspValid,
  output logic cmdRefused
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rdPend;
    logic sel;
    logic sdi;
    logic [7:0] rsp;
    logic rspValid;
    logic refused;
  } mfc_host_s;

  mfc_host_s q_ff;
  mfc_host_s nxt_q;

  // async route only pairs with FSK or OOK; this also keeps GFSK direct mode clocked
  function automatic logic illegal_ctrl(input logic [7:0] v);
    logic [1:0] kind;
    kind = v[mfc_pkg::KIND_HI:mfc_pkg::KIND_LO];
    return v[mfc_pkg::ROUTE_HI:mfc_pkg::ROUTE_LO] == mfc_pkg::ROUTE_NONE
      && kind != mfc_pkg::KIND_FSK && kind != mfc_pkg::KIND_OOK;
  endfunction : illegal_ctrl

  // ==========================================================
  // next state
  always_comb begin
    nxt_q = q_ff;
    nxt_q.wr = 1'b0;
    nxt_q.rd = 1'b0;
    nxt_q.refused = 1'b0;
    nxt_q.rspValid = 1'b0;
    // write wins if both commands arrive together
    if (cmdWr) begin
      if (cmdAddr == mfc_pkg::ADDR_MOD_CTRL && illegal_ctrl(cmdData)) begin
        nxt_q.refused = 1'b1;
      end else begin
        nxt_q.wr = 1'b1;
        nxt_q.addr = cmdAddr;
        nxt_q.wdata = cmdData;
      end
    end else if (cmdRd) begin
      nxt_q.rd = 1'b1;
      nxt_q.addr = cmdAddr;
    end
    // answer is on the port the cycle after the strobe
    nxt_q.rdPend = q_ff.rd;
    if (q_ff.rdPend) begin
      nxt_q.rsp = link.regRdata;
      nxt_q.rspValid = 1'b1;
    end
    // select held high for the whole direct transfer
    nxt_q.sel = directEn;
    nxt_q.sdi = directEn & directBit;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================
  // outputs
  assign link.regAddr = q_ff.addr;
  assign link.regWdata = q_ff.wdata;
  assign link.regWr = q_ff.wr;
  assign link.regRd = q_ff.rd;
  assign link.selPin = q_ff.sel;
  assign link.sdiData = q_ff.sdi;
  assign rspData = q_ff.rsp;
  assign rspValid = q_ff.rspValid;
  assign cmdRefused = q_ff.refused;
endmodule : mfc_host
`default_nettype wire

// ---- testbench/mfc_link_properties.sv ----
// concurrent checks on the register link between controller and radio
`timescale 1ns/1ps
`default_nettype none
module mfc_link_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic selPin,
  input wire logic sdiData
);
  // ==========================================================
  // helpers: places whose read-back is the byte written, and all mapped places
  logic rwPlace;
  logic mapped;
  assign rwPlace = regAddr inside {8'h71, 8'h72, 8'h76, 8'h77, 8'h79, 8'h7A};
  assign mapped = rwPlace || (regAddr inside {8'h73, 8'h74, 8'h75});
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // properties
  a_strobes_apart: assert property (!(regWr && regRd))
    else $error("both strobes at once");
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  a_rw_readback: assert property ((regWr && rwPlace) ##1 (regRd && regAddr == $past(regAddr))
    |=> regRdata == $past(regWdata, 2)) else $error("read-back differs from write");
  a_unmapped_zero: assert property ($past(regRd) && !$past(mapped) |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_band_reserved: assert property ($past(regRd) && $past(regAddr) == 8'h75 |-> !regRdata[7])
    else $error("band reserved bit set");
  a_ofs_reserved: assert property ($past(regRd) && $past(regAddr) == 8'h74 |-> regRdata[7:2] == 6'h00)
    else $error("offset high reserved bits set");
  a_async_kind: assert property (regWr && regAddr == 8'h71 && regWdata[7:6] == 2'b00
    |-> regWdata[1:0] inside {2'b01, 2'b10}) else $error("async route with wrong kind");
  a_gfsk_clock: assert property (regWr && regAddr == 8'h71 && regWdata[1:0] == 2'b11 && !regWdata[5]
    |-> regWdata[7:6] != 2'b00) else $error("direct gfsk without clock route");
  a_sdi_select: assert property (!selPin |-> !sdiData)
    else $error("direct data outside select");
endmodule : mfc_link_properties
`default_nettype wire

// ---- testbench/modulation_frequency_config_tb.sv ----
// self-checking bench: controller and radio ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module modulation_frequency_config_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmdWr = 1'b0, cmdRd = 1'b0, directEn = 1'b0, directBit = 1'b0;
  logic [7:0] cmdAddr = 8'h00, cmdData = 8'h00, rspData;
  logic bitTick = 1'b0, gpioDataIn = 1'b0, fifoDataIn = 1'b0, rxDataRaw = 1'b0, afcValid = 1'b0;
  logic [9:0] afcResult = 10'h000;
  logic rspValid, cmdRefused, txData, rxData, dataClkGpio, dataClkSdo, dataClkIrq;
  logic highBand, sideBand;
  logic [1:0] modulationKind, dataSource;
  logic [18:0] deviationHz;
  logic signed [10:0] offsetUnits;
  logic [10:0] bandStartMhz;
  logic [21:0] carrierKhz;
  int err_count = 0, check_count = 0, cycles = 0;
  mfc_link_if link ();
  mfc_host i_mfc_host (.clk, .rstn, .link, .cmdWr, .cmdRd, .cmdAddr, .cmdData, .directEn,
    .directBit, .rspData, .rspValid, .cmdRefused);
  mfc_device i_mfc_device (.clk, .rstn, .link, .bitTick, .gpioDataIn, .fifoDataIn, .rxDataRaw,
    .afcValid, .afcResult, .txData, .rxData, .dataClkGpio, .dataClkSdo, .dataClkIrq,
    .modulationKind, .dataSource, .highBand, .sideBand, .deviationHz, .offsetUnits,
    .bandStartMhz, .carrierKhz);
  mfc_link_properties i_mfc_link_properties (.clk, .rstn, .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regWr(link.regWr), .regRd(link.regRd),
    .regRdata(link.regRdata), .selPin(link.selPin), .sdiData(link.sdiData));
  // ==========================================================
  // clock and hang guard; a whole run needs well under a thousand cycles
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // refusal shows in the cycle where the bus write would stand
  task automatic hwr(input logic [7:0] a, input logic [7:0] d, input logic refExp);
    @(posedge clk);
    cmdWr <= 1'b1;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge clk);
    cmdWr <= 1'b0;
    #1;
    check({31'h0, cmdRefused}, {31'h0, refExp});
  endtask : hwr
  task automatic hrd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    cmdRd <= 1'b1;
    cmdAddr <= a;
    @(posedge clk);
    cmdRd <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (rspValid === 1'b1) break;
    end
    check({23'h0, rspValid, rspData}, {23'h1, exp});
  endtask : hrd
  // derived outputs lag a write by two edges; three gives the host flop too
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] places [10] = '{8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7A};
    logic [7:0] values [10] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h75, 8'hBB, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      hrd(places[i], values[i]);
    end
    check(deviationHz, 32'd20000);
    check(bandStartMhz, 32'd900);
    check(carrierKhz, 32'd915000);
  endtask : t_reset
  task automatic t_hop_band();
    hwr(8'h79, 8'h02, 1'b0);
    hwr(8'h7A, 8'h05, 1'b0);
    hrd(8'h7A, 8'h05);
    check(carrierKhz, 32'd915100);
    hwr(8'h75, 8'hFF, 1'b0);
    hrd(8'h75, 8'h7F);
    check({19'h0, highBand, sideBand, bandStartMhz}, {21'h3, 11'd1100});
    check(carrierKhz, 32'd1115100);
    hwr(8'h75, 8'h0A, 1'b0);
    settle();
    check(bandStartMhz, 32'd340);
    check(carrierKhz, 32'd347600);
  endtask : t_hop_band
  task automatic t_dev_refuse();
    // 170 kHz deviation keeps the index within 1 to 32 from 10.7 to 340 kbps
    hwr(8'h72, 8'h10, 1'b0);
    hwr(8'h71, 8'h06, 1'b0);
    hrd(8'h72, 8'h10);
    check(deviationHz, 32'd170000);
    for (int k = 0; k < 4; k++) begin
      hwr(8'h71, 8'h20 | 8'(k), (k == 0) || (k == 3));
    end
    hrd(8'h71, 8'h22);
    hwr(8'h71, 8'h13, 1'b1);
    hwr(8'h71, 8'hE3, 1'b0);
    hrd(8'h71, 8'hE3);
    check(modulationKind, 32'd3);
  endtask : t_dev_refuse
  // each route gets the toggling clock alone
  task automatic t_route();
    logic [2:0] c0;
    logic [2:0] hot;
    for (int r = 1; r < 4; r++) begin
      hwr(8'h71, {2'(r), 6'h22}, 1'b0);
      settle();
      hot = 3'b001 << (r - 1);
      c0 = {dataClkIrq, dataClkSdo, dataClkGpio};
      @(posedge clk);
      bitTick <= 1'b1;
      @(posedge clk);
      bitTick <= 1'b0;
      settle();
      check({dataClkIrq, dataClkSdo, dataClkGpio} & ~hot, 32'd0);
      check((c0 ^ {dataClkIrq, dataClkSdo, dataClkGpio}) & hot, {29'h0, hot});
    end
  endtask : t_route
  task automatic t_data();
    hwr(8'h71, 8'h02, 1'b0);
    @(posedge clk);
    gpioDataIn <= 1'b1;
    settle();
    check({dataSource, txData}, 32'd1);
    hwr(8'h71, 8'h2A, 1'b0);
    settle();
    check({dataSource, txData, rxData}, 32'hB);
    hwr(8'h71, 8'h52, 1'b0);
    @(posedge clk);
    directEn <= 1'b1;
    directBit <= 1'b1;
    settle();
    check(txData, 32'd1);
    @(posedge clk);
    directEn <= 1'b0;
    directBit <= 1'b0;
    settle();
    check(txData, 32'd1);
    @(posedge clk);
    directEn <= 1'b1;
    settle();
    check(txData, 32'd0);
  endtask : t_data
  // written offset feeds the math, reads show only the correction latch
  task automatic t_offset();
    hwr(8'h73, 8'hFF, 1'b0);
    hwr(8'h74, 8'h03, 1'b0);
    hrd(8'h73, 8'h00);
    check({21'h0, offsetUnits}, 32'h7FF);
    check(carrierKhz, 32'd347599);
    @(posedge clk);
    afcValid <= 1'b1;
    afcResult <= 10'h2A5;
    @(posedge clk);
    afcValid <= 1'b0;
    hrd(8'h73, 8'hA5);
    hrd(8'h74, 8'h02);
    // high band doubles the offset step
    hwr(8'h75, 8'h2A, 1'b0);
    settle();
    check({21'h0, offsetUnits}, 32'h7FE);
  endtask : t_offset
  // all-ones seed gives nine ones before the first zero
  task automatic t_pn();
    hwr(8'h71, 8'h32, 1'b0);
    settle();
    check(txData, 32'd1);
    @(posedge clk);
    bitTick <= 1'b1;
    repeat (9) @(posedge clk);
    bitTick <= 1'b0;
    settle();
    check(txData, 32'd0);
  endtask : t_pn
  // write then read of one place on consecutive cycles
  task automatic t_back2back();
    @(posedge clk);
    cmdWr <= 1'b1;
    cmdAddr <= 8'h79;
    cmdData <= 8'h33;
    @(posedge clk);
    cmdWr <= 1'b0;
    cmdRd <= 1'b1;
    @(posedge clk);
    cmdRd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({23'h0, rspValid, rspData}, {23'h1, 8'h33});
  endtask : t_back2back
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_hop_band();
    t_dev_refuse();
    t_route();
    t_data();
    t_pn();
    t_offset();
    t_back2back();
    give_verdict();
  end
endmodule : modulation_frequency_config_tb
`default_nettype wire
